// ==== inc/bsc_pkg.sv ====
package bsc_pkg;

    // ******************************
    // timebase
    // ******************************
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned SEC_S = 1;
    localparam int unsigned SEC_CYC = CLK_HZ * SEC_S;

    // ******************************
    // sequence times, seconds
    // ******************************
    typedef logic [7:0] bsc_sec_t;
    localparam bsc_sec_t SEC_MAX = 8'hFF;
    localparam bsc_sec_t INIT_S = 10;
    localparam bsc_sec_t HOLD_MIN_S = 5;
    localparam bsc_sec_t HOLD_MAX_S = 4 * 60;
    localparam bsc_sec_t SBY_FLAME_S = 240;
    localparam bsc_sec_t PREIGN_ACC_S = 30;
    localparam bsc_sec_t ILK_CHK_S = 120;
    localparam bsc_sec_t SW_HOLD_S = 30;
    localparam bsc_sec_t DRIVE_MAX_S = 4 * 60 + 15;
    localparam bsc_sec_t RECYCLE_HOLD_S = 30;
    localparam bsc_sec_t ILK_CLOSE_S = 10;
    localparam bsc_sec_t ILK_MAX_S = 30;
    localparam bsc_sec_t FLAME_PURGE_S = 10;
    localparam bsc_sec_t PILOT_TRIAL_PERIOD_LONG_S = 10;
    localparam bsc_sec_t PILOT_TRIAL_PERIOD_SHORT_S = 4;
    localparam bsc_sec_t TEST_LONG_S = 8;
    localparam bsc_sec_t TEST_SHORT_S = 3;
    localparam bsc_sec_t FLAMEOUT_S = 15;
    localparam bsc_sec_t SPARK_S = 5;
    localparam bsc_sec_t IGN_OFF_S = 10;
    localparam bsc_sec_t REL_SHORT_S = 15;
    localparam bsc_sec_t REL_LONG_S = 30;
    localparam bsc_sec_t RUN_S = 15;
    localparam bsc_sec_t POST_S = 15;
    localparam bsc_sec_t PURGE_DEF_S = 30;

    // cycles a load may disagree with its feedback before lockout
    localparam logic [3:0] SENSE_SETTLE = 4'hF;

    // ******************************
    // second counters
    // ******************************
    localparam int C_STATE = 0;
    localparam int C_PP = 1;
    localparam int C_PURGE = 2;
    localparam int C_PILOT_TRIAL_PERIOD = 3;
    localparam int C_OUT = 4;
    localparam int C_MAIN = 5;
    localparam int C_ACC = 6;
    localparam int C_CHK = 7;
    localparam int NCNT = 8;

    // ******************************
    // types
    // ******************************
    typedef enum {VAR_SEL, VAR_HFP, VAR_INT} bsc_var_e;

    typedef enum {
        ST_INIT, ST_HOLD, ST_STBY, ST_DRV_HI, ST_PURGE, ST_DRV_LO,
        ST_PILOT, ST_MAIN, ST_RUN, ST_POST, ST_LOCK
    } bsc_state_e;

    typedef struct packed {
        logic callHeat;
        logic preIgnIlk;
        logic lockoutIlk;
        logic highFireSw;
        logic lowFireSw;
        logic flameSig;
        logic lineOk;
        logic purgeCardOk;
        logic sysFault;
        logic testSw;
        logic lockoutReset;
        logic pilotPeriodSelectJumper;
        logic pilotReleaseSelectJumper;
        logic startupCheckJumper;
        logic extraWireFitted;
        logic sparkSense;
        logic ignPilotSense;
        logic pilotValveSense;
        logic mainValveSense;
    } bsc_in_s;

endpackage : bsc_pkg

// ==== inc/bsc_tick_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface bsc_tick_if;
    logic secTick;
    modport src (output secTick);
    modport dst (input secTick);
endinterface : bsc_tick_if
`default_nettype wire

// ==== design/bsc_timebase.sv ====
`timescale 1ns/1ns
`default_nettype none
module bsc_timebase #(
    parameter int unsigned SEC_CYCLES = bsc_pkg::SEC_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // one-second strobe
    bsc_tick_if.src tick
);
    localparam int W = (SEC_CYCLES > 1) ? $clog2(SEC_CYCLES) : 1;
    localparam logic [W-1:0] LAST = W'(SEC_CYCLES - 1);

    logic [W-1:0] div_r;
    logic tick_r;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            div_r <= '0;
            tick_r <= 1'b0;
        end else begin
            div_r <= (div_r == LAST) ? '0 : div_r + W'(1);
            tick_r <= (div_r == LAST);
        end
    end

    assign tick.secTick = tick_r;

endmodule : bsc_timebase
`default_nettype wire

// ==== design/bsc_controller.sv ====
// Function
// - power-up or line fault enters ten-second initiate
// - line hold at least 5 s; lockout at 4 min
// - standby flame after 240 s locks out
// - pre-ignition interlock open 30 s total locks out
// - interlock check: string closed 120 s locks out
// - load feedback disagreeing with command locks out
// - purge card or internal fault locks out always
// - call for heat starts blower; high-fire hold
// - fire switch not closed in 4:15 locks out
// - prepurge interlock open: lockout or standby hold
// - running interlock by 10 s, else recycle/lockout
// - high-fire purge: late flame or interlock opens
// - purge end drives low fire, then ignition trial
// - pilot trial 10/4 s needs proven flame
// - spark off after five seconds, sensed off
// - trials ignore pre-ignition; low fire opens locks
// - main valve on; pilot/ignition off after 10 s
// - pilot valve release per variant and jumpers
// - run after 15 s flame; flame loss locks
// - heat ends: fuel off, 15 s postpurge, standby
// - test freezes early pilot trial; flameout timer
// - test holds drive points, purge, run low fire
`timescale 1ns/1ns
`default_nettype none
module bsc_controller #(
    parameter bsc_pkg::bsc_var_e VARIANT = bsc_pkg::VAR_SEL,
    parameter int unsigned SEC_CYCLES = bsc_pkg::SEC_CYC,
    parameter bsc_pkg::bsc_sec_t PURGE_SEC = bsc_pkg::PURGE_DEF_S
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // operating control, interlocks, switches
    input wire logic callHeat,
    input wire logic preIgnIlk,
    input wire logic lockoutIlk,
    input wire logic highFireSw,
    input wire logic lowFireSw,
    // flame, line and health
    input wire logic flameSig,
    input wire logic lineOk,
    input wire logic purgeCardOk,
    input wire logic sysFault,
    // operator
    input wire logic testSw,
    input wire logic lockoutReset,
    // configuration, high = clipped or fitted
    input wire logic pilotPeriodSelectJumper,
    input wire logic pilotReleaseSelectJumper,
    input wire logic startupCheckJumper,
    input wire logic extraWireFitted,
    // load feedback
    input wire logic sparkSense,
    input wire logic ignPilotSense,
    input wire logic pilotValveSense,
    input wire logic mainValveSense,
    // loads
    output logic blowerOut,
    output logic sparkOut,
    output logic ignPilotOut,
    output logic pilotValveOut,
    output logic mainValveOut,
    output logic driveHighOut,
    output logic driveLowOut,
    output logic modulateOut,
    output logic alarmOut,
    // status
    output bsc_pkg::bsc_state_e seqState
);
    import bsc_pkg::*;

    // ******************************
    // input synchronisers
    // ******************************
    bsc_in_s rawIn;
    bsc_in_s syncA_r;
    bsc_in_s in_r;

    assign rawIn = {callHeat, preIgnIlk, lockoutIlk, highFireSw, lowFireSw,
        flameSig, lineOk, purgeCardOk, sysFault, testSw, lockoutReset,
        pilotPeriodSelectJumper, pilotReleaseSelectJumper,
        startupCheckJumper, extraWireFitted, sparkSense, ignPilotSense,
        pilotValveSense, mainValveSense};

    // no reset: cleared flops would read as a missing card
    always_ff @(posedge clk_sys) begin
        syncA_r <= rawIn;
        in_r <= syncA_r;
    end

    // ******************************
    // timebase
    // ******************************
    bsc_tick_if tickIf ();

    bsc_timebase #(.SEC_CYCLES(SEC_CYCLES)) u_timebase (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(tickIf.src)
    );

    wire logic secTick = tickIf.secTick;

    function automatic bsc_sec_t incSat(input bsc_sec_t v);
        return (v == SEC_MAX) ? v : v + 8'h01;
    endfunction : incSat

    // ******************************
    // decode
    // ******************************
    bsc_state_e state_r;
    bsc_state_e stateNxt;
    bsc_sec_t cnt_r [NCNT];
    logic [NCNT-1:0] cntClr;
    logic [NCNT-1:0] cntInc;
    logic hold30_r;
    logic entrySw_r;
    logic ilkSeen_r;
    logic [3:0] misCnt_r;

    wire logic hfp = (VARIANT == VAR_HFP);
    wire logic fatalErr = !in_r.purgeCardOk || in_r.sysFault;
    wire logic misLock = (misCnt_r == SENSE_SETTLE);
    wire logic inPurge = state_r inside {ST_DRV_HI, ST_PURGE, ST_DRV_LO};
    wire logic inTrial = state_r inside {ST_PILOT, ST_MAIN};
    wire logic running = state_r inside {ST_MAIN, ST_RUN};
    wire bsc_sec_t pfepLen = in_r.pilotPeriodSelectJumper ?
        PILOT_TRIAL_PERIOD_SHORT_S : PILOT_TRIAL_PERIOD_LONG_S;
    wire bsc_sec_t testLim = in_r.pilotPeriodSelectJumper ?
        TEST_SHORT_S : TEST_LONG_S;
    // stays frozen while the switch is in test
    wire logic frozen = (state_r == ST_PILOT) && in_r.testSw &&
        (cnt_r[C_PILOT_TRIAL_PERIOD] < testLim);
    wire logic relNever = (VARIANT == VAR_INT) ||
        (VARIANT == VAR_SEL && !in_r.pilotReleaseSelectJumper);
    wire bsc_sec_t relSec = (VARIANT == VAR_SEL && in_r.extraWireFitted) ?
        REL_LONG_S : REL_SHORT_S;
    wire logic ilkCheck = in_r.startupCheckJumper && in_r.lockoutIlk;
    wire logic startOk = in_r.callHeat && in_r.preIgnIlk && !in_r.flameSig &&
        !ilkCheck && (!hold30_r || cnt_r[C_STATE] >= RECYCLE_HOLD_S);
    wire logic hfpLock = hfp && (!in_r.preIgnIlk ||
        (in_r.flameSig && cnt_r[C_PP] >= FLAME_PURGE_S) ||
        (!in_r.lockoutIlk &&
        (cnt_r[C_PP] >= ILK_CLOSE_S || ilkSeen_r)));
    wire logic ilkLate = !hfp && !in_r.lockoutIlk &&
        (cnt_r[C_PP] >= ILK_MAX_S);
    wire logic recycle = !hfp && !in_r.lockoutIlk &&
        (cnt_r[C_PP] >= ILK_CLOSE_S);
    wire logic trialLock = !in_r.lowFireSw ||
        (hfp && !in_r.lockoutIlk);

    // ******************************
    // sequencer
    // ******************************
    always_comb begin
        stateNxt = state_r;
        unique case (state_r)
            ST_INIT: begin
                if (cnt_r[C_STATE] >= INIT_S) stateNxt = ST_STBY;
            end
            ST_HOLD: begin
                if (cnt_r[C_STATE] >= HOLD_MAX_S) stateNxt = ST_LOCK;
                else if (in_r.lineOk && cnt_r[C_STATE] >= HOLD_MIN_S)
                    stateNxt = ST_INIT;
            end
            ST_STBY: begin
                if ((in_r.flameSig && cnt_r[C_STATE] >= SBY_FLAME_S) ||
                    cnt_r[C_ACC] >= PREIGN_ACC_S ||
                    cnt_r[C_CHK] >= ILK_CHK_S)
                    stateNxt = ST_LOCK;
                else if (startOk)
                    stateNxt = hfp ? ST_DRV_HI : ST_PURGE;
            end
            ST_DRV_HI, ST_PURGE, ST_DRV_LO: begin
                if (hfpLock || ilkLate) stateNxt = ST_LOCK;
                else if (!in_r.callHeat) stateNxt = ST_POST;
                else if (!in_r.preIgnIlk) stateNxt = ST_STBY;
                else if (state_r == ST_DRV_HI) begin
                    if (!in_r.highFireSw && cnt_r[C_STATE] >= DRIVE_MAX_S)
                        stateNxt = ST_LOCK;
                    else if (in_r.highFireSw && !in_r.testSw &&
                        (!entrySw_r || cnt_r[C_STATE] >= SW_HOLD_S))
                        stateNxt = ST_PURGE;
                end else if (state_r == ST_PURGE) begin
                    if (cnt_r[C_PURGE] >= PURGE_SEC && in_r.lockoutIlk)
                        stateNxt = ST_DRV_LO;
                end else begin
                    if (!in_r.lowFireSw && cnt_r[C_STATE] >= DRIVE_MAX_S)
                        stateNxt = ST_LOCK;
                    else if (in_r.lowFireSw && !in_r.testSw &&
                        (!entrySw_r || cnt_r[C_STATE] >= SW_HOLD_S))
                        stateNxt = ST_PILOT;
                end
            end
            ST_PILOT: begin
                if (trialLock) stateNxt = ST_LOCK;
                else if (!in_r.callHeat) stateNxt = ST_POST;
                else if (frozen && cnt_r[C_OUT] >= FLAMEOUT_S)
                    stateNxt = ST_LOCK;
                else if (cnt_r[C_PILOT_TRIAL_PERIOD] >= pfepLen)
                    stateNxt = in_r.flameSig ? ST_MAIN : ST_LOCK;
            end
            ST_MAIN: begin
                if (trialLock) stateNxt = ST_LOCK;
                else if (!in_r.callHeat) stateNxt = ST_POST;
                else if (cnt_r[C_MAIN] >= RUN_S)
                    stateNxt = in_r.flameSig ? ST_RUN : ST_LOCK;
            end
            ST_RUN: begin
                if (!in_r.flameSig || (hfp && !in_r.lockoutIlk))
                    stateNxt = ST_LOCK;
                else if (!in_r.callHeat) stateNxt = ST_POST;
            end
            ST_POST: begin
                if (cnt_r[C_STATE] >= POST_S) stateNxt = ST_STBY;
            end
            ST_LOCK: begin
                if (in_r.lockoutReset) stateNxt = ST_INIT;
            end
        endcase
        if (state_r != ST_HOLD && state_r != ST_LOCK && !in_r.lineOk)
            stateNxt = ST_HOLD;
        if (state_r != ST_LOCK && (fatalErr || misLock))
            stateNxt = ST_LOCK;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) state_r <= ST_INIT;
        else state_r <= stateNxt;
    end

    // ******************************
    // second counters
    // ******************************
    assign cntClr[C_STATE] = (stateNxt != state_r);
    assign cntInc[C_STATE] = 1'b1;
    assign cntClr[C_PP] = !inPurge;
    assign cntInc[C_PP] = 1'b1;
    assign cntClr[C_PURGE] = (state_r != ST_PURGE) || recycle;
    assign cntInc[C_PURGE] = !in_r.testSw;
    assign cntClr[C_PILOT_TRIAL_PERIOD] = (state_r != ST_PILOT);
    assign cntInc[C_PILOT_TRIAL_PERIOD] = !frozen;
    assign cntClr[C_OUT] = !frozen || in_r.flameSig;
    assign cntInc[C_OUT] = 1'b1;
    assign cntClr[C_MAIN] = !running;
    assign cntInc[C_MAIN] = 1'b1;
    assign cntClr[C_ACC] = (state_r != ST_STBY);
    assign cntInc[C_ACC] = !in_r.preIgnIlk;
    assign cntClr[C_CHK] = (state_r != ST_STBY) || !ilkCheck ||
        !in_r.callHeat;
    assign cntInc[C_CHK] = 1'b1;

    for (genvar i = 0; i < NCNT; i++) begin : g_cnt
        always_ff @(posedge clk_sys) begin
            if (rst || cntClr[i]) cnt_r[i] <= '0;
            else if (secTick && cntInc[i]) cnt_r[i] <= incSat(cnt_r[i]);
        end
    end

    // ******************************
    // sequence flags
    // ******************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hold30_r <= 1'b0;
            entrySw_r <= 1'b0;
            ilkSeen_r <= 1'b0;
        end else begin
            if (inPurge && stateNxt == ST_STBY) hold30_r <= 1'b1;
            else if (state_r != ST_STBY) hold30_r <= 1'b0;
            // a switch already made at entry earns the extra hold
            if (stateNxt == ST_DRV_HI && state_r != ST_DRV_HI)
                entrySw_r <= in_r.highFireSw;
            else if (stateNxt == ST_DRV_LO && state_r != ST_DRV_LO)
                entrySw_r <= in_r.lowFireSw;
            ilkSeen_r <= inPurge && (ilkSeen_r || in_r.lockoutIlk);
        end
    end

    // ******************************
    // loads
    // ******************************
    wire logic blowerNxt = !(state_r inside {ST_INIT, ST_HOLD, ST_STBY,
        ST_LOCK});
    wire logic sparkNxt = (state_r == ST_PILOT) &&
        (cnt_r[C_PILOT_TRIAL_PERIOD] < SPARK_S);
    wire logic ignPilotNxt = (state_r == ST_PILOT) ||
        (state_r == ST_MAIN && cnt_r[C_MAIN] < IGN_OFF_S);
    wire logic pilotValveNxt = (state_r == ST_PILOT) ||
        (running && (relNever || cnt_r[C_MAIN] < relSec));
    wire logic driveLowNxt = (state_r inside {ST_DRV_LO, ST_PILOT, ST_MAIN,
        ST_POST}) || (state_r == ST_RUN && in_r.testSw);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            {blowerOut, sparkOut, ignPilotOut, pilotValveOut} <= 4'h0;
            {mainValveOut, driveHighOut, driveLowOut} <= 3'h0;
            {modulateOut, alarmOut} <= 2'h0;
        end else begin
            blowerOut <= blowerNxt;
            sparkOut <= sparkNxt;
            ignPilotOut <= ignPilotNxt;
            pilotValveOut <= pilotValveNxt;
            mainValveOut <= running;
            driveHighOut <= hfp && (state_r inside {ST_DRV_HI, ST_PURGE});
            driveLowOut <= driveLowNxt;
            modulateOut <= (state_r == ST_RUN) && !in_r.testSw;
            alarmOut <= (state_r == ST_LOCK);
        end
    end

    assign seqState = state_r;

    // ******************************
    // load feedback
    // ******************************
    // relays and the synchroniser lag the command, so allow a short settle
    wire logic mismatch = (sparkOut ^ in_r.sparkSense) |
        (ignPilotOut ^ in_r.ignPilotSense) |
        (pilotValveOut ^ in_r.pilotValveSense) |
        (mainValveOut ^ in_r.mainValveSense);

    always_ff @(posedge clk_sys) begin
        if (rst || !mismatch) misCnt_r <= 4'h0;
        else if (!misLock) misCnt_r <= misCnt_r + 4'h1;
    end

    // ******************************
    // assertions
    // ******************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // consecutive mismatch cycles, counted apart from the design's counter
    logic [4:0] misRun_r;

    always_ff @(posedge clk_sys) begin
        if (rst || !mismatch) misRun_r <= 5'h00;
        else if (misRun_r != 5'h1F) misRun_r <= misRun_r + 5'h01;
    end

    a_card_fault: assert property (
        state_r != ST_LOCK && fatalErr |=> state_r == ST_LOCK)
        else $error("fault did not lock out");
    a_line_hold: assert property (
        !(state_r inside {ST_HOLD, ST_LOCK}) && !in_r.lineOk && !fatalErr &&
        !misLock |=> state_r == ST_HOLD)
        else $error("line fault did not hold");
    a_hold_min: assert property (
        state_r == ST_HOLD && cnt_r[C_STATE] < HOLD_MIN_S |=>
        state_r inside {ST_HOLD, ST_LOCK})
        else $error("hold left early");
    a_hold_max: assert property (
        state_r == ST_HOLD && cnt_r[C_STATE] >= HOLD_MAX_S |=>
        state_r == ST_LOCK)
        else $error("long hold did not lock out");
    a_sby_flame: assert property (
        state_r == ST_STBY && in_r.flameSig && in_r.lineOk &&
        cnt_r[C_STATE] >= SBY_FLAME_S |=> state_r == ST_LOCK)
        else $error("standby flame not locked out");
    a_acc_open: assert property (
        state_r == ST_STBY && in_r.lineOk && cnt_r[C_ACC] >= PREIGN_ACC_S
        |=> state_r == ST_LOCK)
        else $error("interlock open time not locked out");
    a_sense_lock: assert property (
        mismatch && misRun_r >= {1'h0, SENSE_SETTLE} && state_r != ST_LOCK
        |=> state_r == ST_LOCK)
        else $error("load mismatch not locked out");
    a_spark_cut: assert property (
        state_r == ST_PILOT && cnt_r[C_PILOT_TRIAL_PERIOD] >= SPARK_S |=> !sparkOut)
        else $error("spark on past cut-off");
    a_trial_lowsw: assert property (
        inTrial && !in_r.lowFireSw && in_r.lineOk |=> state_r == ST_LOCK)
        else $error("low fire switch open in trial");
    a_trial_freeze: assert property (
        frozen |=> cnt_r[C_PILOT_TRIAL_PERIOD] == $past(cnt_r[C_PILOT_TRIAL_PERIOD]) ||
        state_r != ST_PILOT)
        else $error("trial timer ran in test");
    a_run_entry: assert property (
        $rose(state_r == ST_RUN) |->
        $past(cnt_r[C_MAIN]) >= RUN_S && $past(in_r.flameSig))
        else $error("run entered early");
    a_post_loads: assert property (
        state_r == ST_POST |=> blowerOut && !mainValveOut && driveLowOut)
        else $error("postpurge loads wrong");
    a_lock_latch: assert property (
        state_r == ST_LOCK && !in_r.lockoutReset |=> state_r == ST_LOCK)
        else $error("lockout released without reset");
    a_lock_loads: assert property (
        state_r == ST_LOCK |=> alarmOut && !mainValveOut && !pilotValveOut &&
        !sparkOut && !ignPilotOut)
        else $error("lockout left fuel on");

    c_reach_run: cover property (state_r == ST_MAIN ##1 state_r == ST_RUN);
    c_postpurge: cover property (state_r == ST_POST ##1 state_r == ST_STBY);
    c_lockout: cover property (state_r == ST_PILOT ##1 state_r == ST_LOCK);
    c_test_hold: cover property (frozen [*4]);

endmodule : bsc_controller
`default_nettype wire

// ==== sim/bsc_field_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module bsc_field_model (
    // clock
    input wire logic clk_sys,
    // loads
    input wire logic sparkOut,
    input wire logic ignPilotOut,
    input wire logic pilotValveOut,
    input wire logic mainValveOut,
    // flame can be withheld to force a failed trial
    input wire logic flameEna,
    // feedback and flame
    output logic sparkSense = 1'h0,
    output logic ignPilotSense = 1'h0,
    output logic pilotValveSense = 1'h0,
    output logic mainValveSense = 1'h0,
    output logic flameSig = 1'h0
);
    // one clock of relay lag, well inside the settle window
    always_ff @(posedge clk_sys) begin
        sparkSense <= sparkOut;
        ignPilotSense <= ignPilotOut;
        pilotValveSense <= pilotValveOut;
        mainValveSense <= mainValveOut;
        flameSig <= flameEna & (pilotValveOut | mainValveOut);
    end
endmodule : bsc_field_model
`default_nettype wire

// ==== sim/bsc_controller_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module bsc_controller_tb;
    localparam int SC = 20;
    logic clk_sys = 1'h0, rst = 1'h1, callHeat = 1'h0, preIgnIlk = 1'h1;
    logic lockoutIlk = 1'h1, highFireSw = 1'h0, lowFireSw = 1'h0;
    logic lineOk = 1'h1, purgeCardOk = 1'h1, sysFault = 1'h0, testSw = 1'h0;
    logic lockoutReset = 1'h0, pps = 1'h0, flameEna = 1'h1;
    logic relJ = 1'h1, chkJ = 1'h0, wireJ = 1'h1;
    logic flameSig, sparkSense, ignPilotSense, pilotValveSense, mainValveSense;
    logic blowerOut, sparkOut, ignPilotOut, pilotValveOut, mainValveOut;
    logic driveHighOut, driveLowOut, modulateOut, alarmOut;
    bsc_pkg::bsc_state_e seqState;
    int nTests = 0, miscompares = 0;

    always #20 clk_sys = ~clk_sys;

    bsc_controller #(.SEC_CYCLES(SC), .PURGE_SEC(8'h03)) bsc_controller_inst (
        .clk_sys(clk_sys), .rst(rst), .callHeat(callHeat),
        .preIgnIlk(preIgnIlk), .lockoutIlk(lockoutIlk),
        .highFireSw(highFireSw), .lowFireSw(lowFireSw), .flameSig(flameSig),
        .lineOk(lineOk), .purgeCardOk(purgeCardOk), .sysFault(sysFault),
        .testSw(testSw), .lockoutReset(lockoutReset),
        .pilotPeriodSelectJumper(pps), .pilotReleaseSelectJumper(relJ),
        .startupCheckJumper(chkJ), .extraWireFitted(wireJ),
        .sparkSense(sparkSense), .ignPilotSense(ignPilotSense),
        .pilotValveSense(pilotValveSense), .mainValveSense(mainValveSense),
        .blowerOut(blowerOut), .sparkOut(sparkOut), .ignPilotOut(ignPilotOut),
        .pilotValveOut(pilotValveOut), .mainValveOut(mainValveOut),
        .driveHighOut(driveHighOut), .driveLowOut(driveLowOut),
        .modulateOut(modulateOut), .alarmOut(alarmOut), .seqState(seqState));

    bsc_field_model bsc_field_model_inst (
        .clk_sys(clk_sys), .sparkOut(sparkOut), .ignPilotOut(ignPilotOut),
        .pilotValveOut(pilotValveOut), .mainValveOut(mainValveOut),
        .flameEna(flameEna), .sparkSense(sparkSense),
        .ignPilotSense(ignPilotSense), .pilotValveSense(pilotValveSense),
        .mainValveSense(mainValveSense), .flameSig(flameSig));

    // ******************************
    // checks and waits
    // ******************************
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", nTests, miscompares);
        if (miscompares == 0 && nTests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up

    task automatic chkBit(input string nm, input logic e, input logic g);
        nTests++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %b got %b", nm, e, g);
        end
    endtask : chkBit

    task automatic chkSt(input bsc_pkg::bsc_state_e e);
        nTests++;
        if (seqState !== e) begin
            miscompares++;
            $display("BAD seqState exp %s got %s", e.name(), seqState.name());
        end
    endtask : chkSt

    // bounded: a hang is reported and ends the run
    task automatic waitSt(input bsc_pkg::bsc_state_e e, input int lim);
        int n;
        n = 0;
        while (seqState !== e && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
        chkSt(e);
        if (seqState !== e) wrap_up();
        repeat (2) @(negedge clk_sys);
    endtask : waitSt

    task automatic toPilot();
        callHeat = 1'h1;
        lowFireSw = 1'h0;
        waitSt(bsc_pkg::ST_PURGE, 10);
        chkBit("blowerOut", 1'h1, blowerOut);
        waitSt(bsc_pkg::ST_DRV_LO, 6 * SC);
        chkBit("driveLowOut", 1'h1, driveLowOut);
        lowFireSw = 1'h1;
        waitSt(bsc_pkg::ST_PILOT, 10);
    endtask : toPilot

    initial begin
        repeat (16) @(negedge clk_sys);
        chkSt(bsc_pkg::ST_INIT);
        chkBit("alarmOut", 1'h0, alarmOut);
        rst = 1'h0;
        repeat (9 * SC) @(negedge clk_sys);
        chkSt(bsc_pkg::ST_INIT);
        waitSt(bsc_pkg::ST_STBY, 3 * SC);
        lineOk = 1'h0;
        waitSt(bsc_pkg::ST_HOLD, 10);
        lineOk = 1'h1;
        repeat (4 * SC) @(negedge clk_sys);
        chkSt(bsc_pkg::ST_HOLD);
        waitSt(bsc_pkg::ST_INIT, 3 * SC);
        waitSt(bsc_pkg::ST_STBY, 12 * SC);
        toPilot();
        chkBit("sparkOut", 1'h1, sparkOut);
        chkBit("ignPilotOut", 1'h1, ignPilotOut);
        chkBit("pilotValveOut", 1'h1, pilotValveOut);
        repeat (7 * SC) @(negedge clk_sys);
        chkBit("sparkOut", 1'h0, sparkOut);
        chkSt(bsc_pkg::ST_PILOT);
        waitSt(bsc_pkg::ST_MAIN, 5 * SC);
        chkBit("mainValveOut", 1'h1, mainValveOut);
        waitSt(bsc_pkg::ST_RUN, 17 * SC);
        chkBit("modulateOut", 1'h1, modulateOut);
        chkBit("ignPilotOut", 1'h0, ignPilotOut);
        chkBit("pilotValveOut", 1'h1, pilotValveOut);
        // clipped jumper plus wire: release 30 s after main valve on
        repeat (16 * SC) @(negedge clk_sys);
        chkBit("pilotValveOut", 1'h0, pilotValveOut);
        callHeat = 1'h0;
        waitSt(bsc_pkg::ST_POST, 10);
        chkBit("mainValveOut", 1'h0, mainValveOut);
        chkBit("pilotValveOut", 1'h0, pilotValveOut);
        chkBit("blowerOut", 1'h1, blowerOut);
        chkBit("driveLowOut", 1'h1, driveLowOut);
        waitSt(bsc_pkg::ST_STBY, 17 * SC);
        chkBit("blowerOut", 1'h0, blowerOut);
        sysFault = 1'h1;
        waitSt(bsc_pkg::ST_LOCK, 10);
        chkBit("alarmOut", 1'h1, alarmOut);
        sysFault = 1'h0;
        repeat (2 * SC) @(negedge clk_sys);
        chkSt(bsc_pkg::ST_LOCK);
        lockoutReset = 1'h1;
        waitSt(bsc_pkg::ST_INIT, 10);
        lockoutReset = 1'h0;
        waitSt(bsc_pkg::ST_STBY, 12 * SC);
        // short trial with no flame must lock well before ten seconds
        flameEna = 1'h0;
        pps = 1'h1;
        toPilot();
        waitSt(bsc_pkg::ST_LOCK, 7 * SC);
        chkBit("pilotValveOut", 1'h0, pilotValveOut);
        // test switch freezes the short trial; flameout timer then locks
        lockoutReset = 1'h1;
        waitSt(bsc_pkg::ST_INIT, 10);
        lockoutReset = 1'h0;
        waitSt(bsc_pkg::ST_STBY, 12 * SC);
        toPilot();
        testSw = 1'h1;
        repeat (8 * SC) @(negedge clk_sys);
        chkSt(bsc_pkg::ST_PILOT);
        waitSt(bsc_pkg::ST_LOCK, 10 * SC);
        testSw = 1'h0;
        // interlock check on: string closed with heat called never starts
        chkJ = 1'h1;
        lockoutReset = 1'h1;
        waitSt(bsc_pkg::ST_INIT, 10);
        lockoutReset = 1'h0;
        waitSt(bsc_pkg::ST_STBY, 12 * SC);
        repeat (100 * SC) @(negedge clk_sys);
        chkSt(bsc_pkg::ST_STBY);
        waitSt(bsc_pkg::ST_LOCK, 30 * SC);
        wrap_up();
    end
endmodule : bsc_controller_tb
`default_nettype wire
